/* File: hdl/rsc_seconds_top.sv */
// Seconds-count stage with AHB-Lite register access.
// Assumes a single-master AHB-Lite bus whose hready is this slave's hreadyout.
`timescale 1ns/10ps
`default_nettype none
module rsc_seconds_top #(
  parameter int TICK_CYCLES = rsc_pkg::RSC_TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic minute_carry
);
  import rsc_pkg::*;

  rsc_reg_if rif ();

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic ph_wr;
  logic ph_rd;
  logic [11:0] ph_addr;
  logic [1:0] ctrl;
  logic [7:0] seconds_count;
  logic [2:0] busy_cnt;
  logic update_in_progress;
  rsc_state_t state;
  rsc_state_t next_state;

  wire logic take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 12'h000;
    end else begin
      ph_wr <= take && hwrite;
      ph_rd <= take && !hwrite;
      ph_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= RSC_CTRL_RESET;
    end else if (ph_wr && ph_addr == RSC_OFS_CONTROL) begin
      ctrl <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr)
        RSC_OFS_SECONDS_COUNT: hrdata <= {24'h00_0000, rif.busy, rif.seconds[6:0]};
        RSC_OFS_CONTROL: hrdata <= {30'h0000_0000, ctrl};
        RSC_OFS_TICK_DIV: hrdata <= 32'(TICK_CYCLES);
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states; every response is OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rif.run = ctrl[RSC_CTRL_RUN_BIT];
  assign rif.free_run = ctrl[RSC_CTRL_FRC_BIT];
  assign rif.wr_seconds = ph_wr && ph_addr == RSC_OFS_SECONDS_COUNT;
  assign rif.wdata = hwdata[7:0];

  rsc_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .rif(rif)
  );

  // ---------------------------------------------------------------
  // Seconds core
  // ---------------------------------------------------------------
  function automatic logic [7:0] bcd_next(input logic [7:0] v, output logic carry);
    logic [3:0] u;
    logic [2:0] t;
    u = v[3:0];
    t = v[6:4];
    carry = 1'b0;
    if (u >= RSC_UNITS_MAX) begin
      u = 4'h0;
      if (t >= RSC_TENS_MAX) begin
        t = 3'h0;
        carry = 1'b1;
      end else begin
        t = t + 3'h1;
      end
    end else begin
      u = u + 4'h1;
    end
    bcd_next = {1'b0, t, u};
  endfunction

  // The update is stretched over a few cycles so that a read racing the
  // tick sees busy; software must then read again.
  always_comb begin
    case (state)
      RSC_IDLE: next_state = rif.tick ? RSC_BUSY : RSC_IDLE;
      RSC_BUSY: next_state = (busy_cnt == 3'(RSC_BUSY_CYCLES - 1)) ? RSC_STEP : RSC_BUSY;
      RSC_STEP: next_state = RSC_IDLE;
      default: next_state = RSC_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= RSC_IDLE;
      busy_cnt <= 3'h0;
    end else begin
      state <= next_state;
      busy_cnt <= (state == RSC_BUSY) ? busy_cnt + 3'h1 : 3'h0;
    end
  end

  logic [7:0] stepped;
  logic wrap;
  always_comb begin
    stepped = bcd_next(seconds_count, wrap);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seconds_count <= RSC_SECONDS_RESET;
      minute_carry <= 1'b0;
    end else begin
      minute_carry <= 1'b0;
      if (rif.wr_seconds) begin
        seconds_count <= rif.free_run ? rif.wdata : {1'b0, rif.wdata[6:0]};
      end else if (state == RSC_STEP) begin
        if (rif.free_run) begin
          seconds_count <= seconds_count + 8'h01;
        end else begin
          seconds_count <= stepped;
          minute_carry <= wrap;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      update_in_progress <= 1'b0;
    end else begin
      update_in_progress <= (next_state != RSC_IDLE);
    end
  end

  assign rif.seconds = seconds_count;
  assign rif.busy = update_in_progress;
  assign rif.minute_carry = minute_carry;
endmodule
`default_nettype wire

/* File: hdl/rsc_pkg.sv */
// Package of constants for the seconds-count stage of the real-time clock.
// Assumes a single 125 MHz clock domain and an AHB-Lite register bus.
//
// How it works
// - Seconds held as BCD 00 to 59.
// - Free running mode: plain 8-bit binary counter; reads show only bits 6:0.
// - Bit 7 busy high while time updates.
// - Tens digit in bits 6:4 counts 0-5.
// - Units digit advances each second, 0-9.
// - Units wrap past 9 carries into tens.
package rsc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] RSC_OFS_SECONDS_COUNT = 12'h000;
  localparam logic [11:0] RSC_OFS_CONTROL = 12'h004;
  localparam logic [11:0] RSC_OFS_TICK_DIV = 12'h008;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int RSC_BUSY_BIT = 7;
  localparam int RSC_TENS_LSB = 4;
  localparam int RSC_CTRL_RUN_BIT = 0;
  localparam int RSC_CTRL_FRC_BIT = 1;
  localparam logic [7:0] RSC_SECONDS_RESET = 8'h00;
  localparam logic [1:0] RSC_CTRL_RESET = 2'h0;
  localparam logic [3:0] RSC_UNITS_MAX = 4'h9;
  localparam logic [2:0] RSC_TENS_MAX = 3'h5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int RSC_CLK_MHZ = 125;
  localparam int RSC_TICK_S = 1;
  localparam int RSC_TICK_CYCLES = RSC_TICK_S * RSC_CLK_MHZ * 1000000;
  // Busy is shown for this many cycles plus the step cycle, just before each update.
  localparam int RSC_BUSY_CYCLES = 4;

  typedef enum logic [1:0] {
    RSC_IDLE = 2'b00,
    RSC_BUSY = 2'b01,
    RSC_STEP = 2'b11
  } rsc_state_t;

endpackage

/* File: hdl/rsc_reg_if.sv */
// Interface joining the bus slave to the seconds counter core.
// Assumes both ends sit on hclk.
`timescale 1ns/10ps
`default_nettype none
interface rsc_reg_if;
  logic wr_seconds;
  logic [7:0] wdata;
  logic [7:0] seconds;
  logic busy;
  logic run;
  logic free_run;
  logic tick;
  logic minute_carry;
  modport slave (output wr_seconds, output wdata, output run, output free_run, input seconds, input busy);
  modport core (input wr_seconds, input wdata, input run, input free_run, input tick, output seconds,
                output busy, output minute_carry);
  modport ticker (input run, output tick);
endinterface
`default_nettype wire

/* File: hdl/rsc_tick_gen.sv */
// One-second tick generator for the seconds stage.
// Assumes hclk at the rate in the package; the divisor is a parameter.
`timescale 1ns/10ps
`default_nettype none
module rsc_tick_gen #(
  parameter int TICK_CYCLES = rsc_pkg::RSC_TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  rsc_reg_if.ticker rif
);
  import rsc_pkg::*;

  logic [31:0] count;
  logic tick_q;

  // The divider is held at zero while stopped so restart gives a full second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (!rif.run) begin
      count <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (count == 32'(TICK_CYCLES - 1)) begin
      count <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  assign rif.tick = tick_q;
endmodule
`default_nettype wire

/* File: verification/rsc_seconds_assertions.sv */
// Checker for the bus ports of the seconds stage.
// Assumes it is bound to rsc_seconds_top, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module rsc_seconds_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic minute_carry
);
  import rsc_pkg::*;
  logic rd_q;
  logic ctl_q;
  logic fr;
  logic [11:0] addr_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // The mode bit is shadowed from bus writes, since the core is not visible here.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      ctl_q <= 1'b0;
      fr <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      rd_q <= hsel & hready & htrans[1] & !hwrite;
      ctl_q <= hsel & hready & htrans[1] & hwrite & (haddr == RSC_OFS_CONTROL);
      addr_q <= haddr;
      if (ctl_q) begin
        fr <= hwdata[1];
      end
    end
  end
  resp_okay_a: assert property (hreadyout && !hresp) else $error("slave stalled or answered with error");
  carry_pulse_a: assert property (minute_carry |=> !minute_carry [*8]) else $error("carry too long");
  carry_bcd_a: assert property (minute_carry |-> !fr) else $error("carry in free running mode");
  tens_range_a: assert property (rd_q && !fr && addr_q == RSC_OFS_SECONDS_COUNT |-> hrdata[6:4] <= RSC_TENS_MAX)
    else $error("tens digit out of range");
  units_range_a: assert property (rd_q && !fr && addr_q == RSC_OFS_SECONDS_COUNT |-> hrdata[3:0] <= RSC_UNITS_MAX)
    else $error("units digit out of range");
  word_width_a: assert property (rd_q && addr_q == RSC_OFS_SECONDS_COUNT |-> hrdata[31:8] == '0)
    else $error("seconds wider than eight bits");
  unmapped_zero_a: assert property (rd_q && addr_q > RSC_OFS_TICK_DIV |-> hrdata == '0)
    else $error("unmapped read not zero");
endmodule
bind rsc_seconds_top rsc_seconds_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .minute_carry(minute_carry));
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the seconds stage.
// Assumes the checker is bound to the design.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rsc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, minute_carry;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  wire hready;
  int error_cnt, comparisons, carries;
  // A short second keeps every scenario within a few dozen cycles.
  localparam int SIM_TICK = 20;
  assign hready = hreadyout;
  rsc_seconds_top #(.TICK_CYCLES(SIM_TICK)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .minute_carry(minute_carry));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) if (minute_carry === 1'b1) carries++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Stops the count, loads a start value, runs in the given mode and waits for the next settled value.
  task automatic step(input logic [1:0] mode, input logic [7:0] start, input logic [7:0] exp, input int cexp);
    logic [31:0] r;
    int c0, busy, n;
    xfer(RSC_OFS_CONTROL, 1'b1, '0, r);
    xfer(RSC_OFS_SECONDS_COUNT, 1'b1, {24'h00_0000, start}, r);
    c0 = carries;
    busy = 0;
    n = 0;
    xfer(RSC_OFS_CONTROL, 1'b1, {30'h0000_0000, mode}, r);
    r = {24'h00_0000, start};
    while (n < 300 && (r[7] === 1'b1 || r[7:0] === start)) begin
      xfer(RSC_OFS_SECONDS_COUNT, 1'b0, '0, r);
      if (r[7] === 1'b1) busy = 1;
      n++;
    end
    chk(r, {24'h00_0000, exp});
    chk(busy, 1);
    chk(carries - c0, cexp);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    error_cnt = 0;
    comparisons = 0;
    carries = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(RSC_OFS_SECONDS_COUNT, 1'b0, '0, q);
    chk(q, '0);
    xfer(12'h00C, 1'b0, '0, q);
    chk(q, '0);
    xfer(RSC_OFS_TICK_DIV, 1'b0, '0, q);
    chk(q, 32'(SIM_TICK));
    step(2'h1, 8'h00, 8'h01, 0);
    step(2'h1, 8'h09, 8'h10, 0);
    step(2'h1, 8'h45, 8'h46, 0);
    step(2'h1, 8'h59, 8'h00, 1);
    step(2'h3, 8'h09, 8'h0a, 0);
    results;
  end
  // A hang ends the run well after the longest expected sequence.
  initial begin
    #200000;
    error_cnt++;
    results;
  end
endmodule
`default_nettype wire
